// ### hw/gcn_top.sv
// Global clock network, configuration controls and synthesizing PLL
//
// Functional notes
// - Eight global buffers, each pin except 4 and 5 drives one
// - Any buffer can clock a logic block
// - Four buffers reach logic block inputs
// - Even buffers reset, odd buffers enable
// - Buffers 4/5 take low/high oscillators
// - Unused global pins stay plain inputs, except pins 4 and 5, which read zero
// - Hi-z held throughout configuration
// - Global reset held throughout configuration
// - Reference from pin, oscillators or fabric
// - External feedback only when selected
// - Feedback divider multiplies reference frequency
// - Output divider powers of two, 1..64
// - Lock rises aligned, falls on loss
// - Bypass passes reference straight through
// - Dynamic phase shift drops lock, relock
// - Fine delay used only in dynamic mode
// - Freeze holds output at last level
// - Fabric output matches global output frequency
// - Synth clock may feed buffers 4, 5
// - Serial port reprograms PLL dividers
//
// Implementation choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`include "gcn_consts.svh"
module gcn_top #(
  parameter int N_IO     = 8,
  parameter int PER_W    = 16,
  parameter int LF_HALF  = 500,
  parameter int HF_HALF  = 1,
  parameter int LOCK_CYC = `GCN_LOCK_CYC
) (
  // Clock and reset
  input  wire logic              I_SYS_CLK,
  input  wire logic              I_RST,
  // Wishbone slave
  input  wire logic              I_WB_CYC,
  input  wire logic              I_WB_STB,
  input  wire logic              I_WB_WE,
  input  wire logic [7:0]        I_WB_ADR,
  input  wire logic [3:0]        I_WB_SEL,
  input  wire logic [31:0]       I_WB_DAT,
  output logic      [31:0]       O_WB_DAT,
  output logic                   O_WB_ACK,
  // Configuration controls
  input  wire logic              I_CFG_ACTIVE,
  output logic                   O_GLOBAL_HIZ_CTL,
  output logic                   O_GLOBAL_RESET,
  // Global pins and buffers
  input  wire logic [7:0]        I_GLOBAL_PIN,
  output logic      [7:0]        O_GPIO_IN,
  output logic      [7:0]        O_GLOBAL_BUFFER,
  // User I/O pads
  input  wire logic [N_IO-1:0]   I_IO_OUT,
  input  wire logic [N_IO-1:0]   I_IO_DRIVE,
  output logic      [N_IO-1:0]   O_IO_OUT,
  output logic      [N_IO-1:0]   O_IO_OE_N,
  // Logic block taps
  output logic                   O_LB_CLK,
  output logic      [3:0]        O_LB_LOGIC,
  output logic                   O_LB_SR,
  output logic                   O_LB_CE,
  // PLL
  input  wire logic              I_REF_CLOCK_IN,
  input  wire logic              I_REF_FABRIC,
  input  wire logic              I_EXT_FEEDBACK_IN,
  input  wire logic              I_PLL_RESET_N,
  input  wire logic              I_BYPASS,
  input  wire logic [7:0]        I_FINE_DELAY_CTL,
  input  wire logic              I_LOWPOWER_FREEZE,
  input  wire logic              I_GATE_ENABLE_A,
  input  wire logic              I_CFG_SERIAL_CLK,
  input  wire logic              I_CFG_SERIAL_DIN,
  output logic                   O_SYNTH_CLOCK_GLOBAL,
  output logic                   O_SYNTH_CLOCK_FABRIC,
  output logic                   O_LOCK
);
  // ==========================================================
  // Declarations
  gcn_pkg::gcn_ctrl_t  ctrl_reg, ctrl_next;     // Sources, modes
  gcn_pkg::gcn_div_t   div_reg, div_next;       // Dividers
  gcn_pkg::gcn_route_t route_reg, route_next;   // Block taps
  logic [7:0]  pinuse_reg, pinuse_next;         // Pin drives a buffer
  logic [15:0] ser_reg, ser_next;               // Serial shifter
  logic [3:0]  sercnt_reg, sercnt_next;         // Bits received
  logic        sclk_reg, sclk_next;             // Last serial clock
  logic        ack_next;
  logic [31:0] rdat_next;
  logic        wr_en;
  logic [7:0]  adr_w;                           // Word-aligned address
  // Oscillators
  logic [15:0] lf_cnt_reg, lf_cnt_next;
  logic [15:0] hf_cnt_reg, hf_cnt_next;
  logic        lf_reg, lf_next, hf_reg, hf_next;
  // PLL
  gcn_pkg::gcn_pll_state_t st_reg, st_next;
  logic [PER_W-1:0] per_cnt_reg, per_cnt_next;  // Running period
  logic [PER_W-1:0] per_reg, per_next;          // Last ref period
  logic [PER_W:0]   acc_reg, acc_next;          // Phase accumulator
  logic [6:0]  odc_reg, odc_next;               // Output divider count
  logic [15:0] lk_reg, lk_next;                 // Lock timer
  logic [7:0]  dly_reg;                         // Last fine delay
  logic ref_d_reg, fb_d_reg, fbs_reg, fbs_next;
  logic vco_reg, vco_next, out_reg, out_next;
  logic lock_next, syn_next;
  logic ref_lvl, ref_rise, fb_lvl, fb_rise, good, lost, dly_chg;
  logic frozen;
  logic [PER_W:0] half, dfp;
  logic [6:0]  fbd, ndiv;
  logic [2:0]  olog;
  // Distribution
  logic [7:0]  global_buffer_next;
  logic [7:0]  gpio_next;

  // ==========================================================
  // Byte-lane merge for partial writes
  function automatic logic [31:0] gcn_merge(input logic [31:0] o,
      input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================
  // Register file and serial port, next values
  always_comb begin
    adr_w       = {I_WB_ADR[7:2], 2'b00};
    wr_en       = I_WB_CYC & I_WB_STB & I_WB_WE & ~O_WB_ACK;
    ack_next    = I_WB_CYC & I_WB_STB & ~O_WB_ACK;
    ctrl_next   = ctrl_reg;
    div_next    = div_reg;
    route_next  = route_reg;
    pinuse_next = pinuse_reg;
    ser_next    = ser_reg;
    sercnt_next = sercnt_reg;
    sclk_next   = I_CFG_SERIAL_CLK;
    rdat_next   = 32'h0000_0000;       // Unmapped reads give zero
    unique case (adr_w)
      `GCN_ADR_CTRL:    rdat_next = 32'(ctrl_reg);
      `GCN_ADR_DIV:     rdat_next = 32'(div_reg);
      `GCN_ADR_ROUTE:   rdat_next = 32'(route_reg);
      `GCN_ADR_PINUSE:  rdat_next = 32'(pinuse_reg);
      `GCN_ADR_STATUS:  rdat_next = 32'({st_reg, O_LOCK});
      `GCN_ADR_SERWORD: rdat_next = 32'(ser_reg);
      default:          rdat_next = 32'h0000_0000;
    endcase
    if (!ack_next) begin
      rdat_next = 32'h0000_0000;
    end
    // Writes take effect at the acknowledging edge
    if (wr_en) begin
      unique case (adr_w)
        `GCN_ADR_CTRL:   ctrl_next   = 5'(gcn_merge(32'(ctrl_reg), I_WB_DAT, I_WB_SEL));
        `GCN_ADR_DIV:    div_next    = 10'(gcn_merge(32'(div_reg), I_WB_DAT, I_WB_SEL));
        `GCN_ADR_ROUTE:  route_next  = 19'(gcn_merge(32'(route_reg), I_WB_DAT, I_WB_SEL));
        `GCN_ADR_PINUSE: pinuse_next = 8'(gcn_merge(32'(pinuse_reg), I_WB_DAT, I_WB_SEL));
        default:         ;             // Read-only or unmapped
      endcase
    end
    // One bit per serial clock rise, MSB first
    if (I_CFG_SERIAL_CLK & ~sclk_reg) begin
      ser_next    = {ser_reg[14:0], I_CFG_SERIAL_DIN};
      sercnt_next = sercnt_reg + 4'h1;
      // A full word reloads the dividers; it wins over a bus write
      if (sercnt_reg == `GCN_SER_LAST) begin
        div_next = ser_next[$bits(gcn_pkg::gcn_div_t)-1:0];
      end
    end
    // Configuration wipes the settings back to wake-up values
    if (I_CFG_ACTIVE) begin
      ctrl_next   = `GCN_RST_CTRL;
      div_next    = `GCN_RST_DIV;
      route_next  = `GCN_RST_ROUTE;
      pinuse_next = `GCN_RST_PINUSE;
      sercnt_next = 4'h0;
    end
  end

  // Register file and serial port, storage
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      ctrl_reg   <= `GCN_RST_CTRL;
      div_reg    <= `GCN_RST_DIV;
      route_reg  <= `GCN_RST_ROUTE;
      pinuse_reg <= `GCN_RST_PINUSE;
      ser_reg    <= 16'h0000;
      sercnt_reg <= 4'h0;
      sclk_reg   <= 1'b0;
      O_WB_ACK   <= 1'b0;
      O_WB_DAT   <= 32'h0000_0000;
    end else begin
      ctrl_reg   <= ctrl_next;
      div_reg    <= div_next;
      route_reg  <= route_next;
      pinuse_reg <= pinuse_next;
      ser_reg    <= ser_next;
      sercnt_reg <= sercnt_next;
      sclk_reg   <= sclk_next;
      O_WB_ACK   <= ack_next;
      O_WB_DAT   <= rdat_next;
    end
  end

  // ==========================================================
  // On-chip oscillators as divided square waves
  always_comb begin
    lf_cnt_next = lf_cnt_reg + 16'h0001;
    hf_cnt_next = hf_cnt_reg + 16'h0001;
    lf_next     = lf_reg;
    hf_next     = hf_reg;
    if (lf_cnt_reg == 16'(LF_HALF - 1)) begin
      lf_cnt_next = 16'h0000;
      lf_next     = ~lf_reg;
    end
    if (hf_cnt_reg == 16'(HF_HALF - 1)) begin
      hf_cnt_next = 16'h0000;
      hf_next     = ~hf_reg;
    end
  end

  // Oscillator storage
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      lf_cnt_reg <= 16'h0000;
      hf_cnt_reg <= 16'h0000;
      lf_reg     <= 1'b0;
      hf_reg     <= 1'b0;
    end else begin
      lf_cnt_reg <= lf_cnt_next;
      hf_cnt_reg <= hf_cnt_next;
      lf_reg     <= lf_next;
      hf_reg     <= hf_next;
    end
  end

  // ==========================================================
  // PLL model. The reference is sampled by the system clock, so
  // the synthesized rate can never exceed half the system rate.
  always_comb begin
    unique case (ctrl_reg.ref_sel)
      2'd0: ref_lvl = I_REF_CLOCK_IN;
      2'd1: ref_lvl = lf_reg;
      2'd2: ref_lvl = hf_reg;
      2'd3: ref_lvl = I_REF_FABRIC;
    endcase
    ref_rise = ref_lvl & ~ref_d_reg;
    // Internal feedback is the oscillator itself
    fb_lvl   = ctrl_reg.fb_ext ? I_EXT_FEEDBACK_IN : vco_reg;
    fb_rise  = fb_lvl & ~fb_d_reg;
    good     = fbs_reg | fb_rise;
    frozen   = I_LOWPOWER_FREEZE & I_GATE_ENABLE_A;
    dly_chg  = ctrl_reg.delay_dyn & (I_FINE_DELAY_CTL != dly_reg);
    fbd      = (div_reg.fb_div == 7'h00) ? 7'h01 : div_reg.fb_div;
    olog     = (div_reg.out_log2 > `GCN_ODIV_MAX) ? `GCN_ODIV_MAX
                                                  : div_reg.out_log2;
    ndiv     = 7'h01 << olog;
    half     = {1'b0, per_reg} >> 1;
    if (half == '0) begin
      half = (PER_W+1)'(1);
    end
    // Period measurement, saturating when the reference stops
    per_cnt_next = (&per_cnt_reg) ? per_cnt_reg : per_cnt_reg + 1'b1;
    per_next     = per_reg;
    lost         = &per_cnt_reg;
    dfp          = '0;
    if (ref_rise) begin
      per_cnt_next = (PER_W)'(1);
      per_next     = per_cnt_reg;
      dfp = (per_cnt_reg > per_reg) ? {1'b0, per_cnt_reg - per_reg}
                                    : {1'b0, per_reg - per_cnt_reg};
      good = good & (dfp <= (PER_W+1)'(`GCN_LOCK_TOL));
    end
    // Feedback-seen flag: a new edge beats the clear
    fbs_next = fb_rise | (fbs_reg & ~ref_rise);
    // Accumulator: reference half period times fb_div toggles
    acc_next = acc_reg + (PER_W+1)'(fbd);
    vco_next = vco_reg;
    odc_next = odc_reg;
    out_next = out_reg;
    if (acc_next >= half) begin
      acc_next = acc_next - half;
      vco_next = ~vco_reg;
      if (odc_reg >= ndiv - 7'h01) begin
        odc_next = 7'h00;
        out_next = ~out_reg;
      end else begin
        odc_next = odc_reg + 7'h01;
      end
    end
    // Dynamic shift jumps the phase by the new delay
    if (dly_chg) begin
      acc_next = acc_next + (PER_W+1)'(I_FINE_DELAY_CTL);
    end
    // Freeze keeps accumulator, dividers and output at rest; lock tracking runs on
    if (frozen) begin
      acc_next = acc_reg;
      vco_next = vco_reg;
      odc_next = odc_reg;
      out_next = out_reg;
    end
    // Lock tracking
    st_next = st_reg;
    lk_next = lk_reg;
    unique case (st_reg)
      gcn_pkg::PLL_HOLD: begin
        lk_next = 16'h0000;
        st_next = gcn_pkg::PLL_ACQUIRE;
      end
      gcn_pkg::PLL_ACQUIRE: begin
        lk_next = lk_reg + 16'h0001;
        if ((ref_rise & ~good) | lost | dly_chg) begin
          lk_next = 16'h0000;
        end else if (lk_reg >= 16'(LOCK_CYC - 1)) begin
          st_next = gcn_pkg::PLL_LOCKED;
        end
      end
      gcn_pkg::PLL_LOCKED: begin
        if ((ref_rise & ~good) | lost | dly_chg) begin
          st_next = gcn_pkg::PLL_ACQUIRE;
          lk_next = 16'h0000;
        end
      end
      default: st_next = gcn_pkg::PLL_HOLD;  // Unused code recovers through hold
    endcase
    // PLL reset stops synthesis and forgets lock
    if (!I_PLL_RESET_N) begin
      st_next  = gcn_pkg::PLL_HOLD;
      acc_next = '0;
      vco_next = 1'b0;
      odc_next = 7'h00;
      out_next = 1'b0;
    end
    lock_next = (st_next == gcn_pkg::PLL_LOCKED);
    // Bypass chooses the reference; freeze holds the pin level
    syn_next = I_BYPASS ? ref_lvl : out_next;
    if (frozen) begin
      syn_next = O_SYNTH_CLOCK_GLOBAL;
    end
  end

  // PLL storage
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      st_reg      <= gcn_pkg::PLL_HOLD;
      per_cnt_reg <= '0;
      per_reg     <= '0;
      acc_reg     <= '0;
      odc_reg     <= 7'h00;
      lk_reg      <= 16'h0000;
      dly_reg     <= 8'h00;
      ref_d_reg   <= 1'b0;
      fb_d_reg    <= 1'b0;
      fbs_reg     <= 1'b0;
      vco_reg     <= 1'b0;
      out_reg     <= 1'b0;
      O_LOCK      <= 1'b0;
      O_SYNTH_CLOCK_GLOBAL <= 1'b0;
      O_SYNTH_CLOCK_FABRIC <= 1'b0;
    end else begin
      st_reg      <= st_next;
      per_cnt_reg <= per_cnt_next;
      per_reg     <= per_next;
      acc_reg     <= acc_next;
      odc_reg     <= odc_next;
      lk_reg      <= lk_next;
      dly_reg     <= I_FINE_DELAY_CTL;
      ref_d_reg   <= ref_lvl;
      fb_d_reg    <= fb_lvl;
      fbs_reg     <= fbs_next;
      vco_reg     <= vco_next;
      out_reg     <= out_next;
      O_LOCK      <= lock_next;
      O_SYNTH_CLOCK_GLOBAL <= syn_next;
      O_SYNTH_CLOCK_FABRIC <= syn_next;
    end
  end

  // ==========================================================
  // Global buffers and pins, next values
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      global_buffer_next[i] = pinuse_reg[i] & I_GLOBAL_PIN[i];
      gpio_next[i] = ~pinuse_reg[i] & I_GLOBAL_PIN[i];
    end
    global_buffer_next[4] = ctrl_reg.glob_synth ? O_SYNTH_CLOCK_GLOBAL : lf_reg;
    global_buffer_next[5] = ctrl_reg.glob_synth ? O_SYNTH_CLOCK_GLOBAL : hf_reg;
    gpio_next[4] = 1'b0;            // No pin behind buffers 4, 5
    gpio_next[5] = 1'b0;
  end

  // Distribution storage; taps read the registered buffers
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_GLOBAL_BUFFER  <= 8'h00;
      O_GPIO_IN        <= 8'h00;
      O_LB_CLK         <= 1'b0;
      O_LB_LOGIC       <= 4'h0;
      O_LB_SR          <= 1'b1;
      O_LB_CE          <= 1'b0;
      O_GLOBAL_HIZ_CTL <= 1'b1;
      O_GLOBAL_RESET   <= 1'b1;
      O_IO_OUT         <= '0;
      O_IO_OE_N        <= '1;
    end else begin
      O_GLOBAL_BUFFER  <= global_buffer_next;
      O_GPIO_IN        <= gpio_next;
      O_LB_CLK         <= O_GLOBAL_BUFFER[route_reg.clk_sel];
      O_LB_LOGIC       <= {O_GLOBAL_BUFFER[route_reg.logic3],
                           O_GLOBAL_BUFFER[route_reg.logic2],
                           O_GLOBAL_BUFFER[route_reg.logic1],
                           O_GLOBAL_BUFFER[route_reg.logic0]};
      O_LB_SR          <= O_GLOBAL_BUFFER[{route_reg.sr_sel, 1'b0}] | I_CFG_ACTIVE;
      O_LB_CE          <= O_GLOBAL_BUFFER[{route_reg.ce_sel, 1'b1}];
      O_GLOBAL_HIZ_CTL <= I_CFG_ACTIVE;
      O_GLOBAL_RESET   <= I_CFG_ACTIVE;
      O_IO_OUT         <= I_IO_OUT;
      O_IO_OE_N        <= ~I_IO_DRIVE | {N_IO{I_CFG_ACTIVE}};
    end
  end
endmodule

// ### hw/gcn_consts.svh
// Constant offsets, reset values and timing counts for the global clock network
`ifndef GCN_CONSTS_SVH
`define GCN_CONSTS_SVH
// ==========================================================
// Register byte addresses
`define GCN_ADR_CTRL    8'h00
`define GCN_ADR_DIV     8'h04
`define GCN_ADR_ROUTE   8'h08
`define GCN_ADR_PINUSE  8'h0C
`define GCN_ADR_STATUS  8'h10
`define GCN_ADR_SERWORD 8'h14
// ==========================================================
// Reset values
`define GCN_RST_CTRL    5'h00
`define GCN_RST_DIV     10'h001
`define GCN_RST_ROUTE   19'h0_0000
`define GCN_RST_PINUSE  8'h00
// ==========================================================
// Timing: lock acquire time and system clock rate
`define GCN_LOCK_ACQ_US 50
`define GCN_SYS_MHZ     10
`define GCN_LOCK_CYC    (`GCN_LOCK_ACQ_US * `GCN_SYS_MHZ)
// Allowed reference period wobble, in system cycles
`define GCN_LOCK_TOL    2
// Largest output divider exponent (divide by 64)
`define GCN_ODIV_MAX    3'h6
// Serial word length and position of the last bit
`define GCN_SER_LEN     16
`define GCN_SER_LAST    4'hF
`endif

// ### hw/gcn_pkg.sv
// Types shared by the global clock network design
package gcn_pkg;
  // ==========================================================
  // PLL lock tracking states
  typedef enum logic [1:0] {
    PLL_HOLD,
    PLL_ACQUIRE,
    PLL_LOCKED
  } gcn_pll_state_t;
  // ==========================================================
  // Control register: sources and modes
  typedef struct packed {
    logic       glob_synth; // Synth clock onto buffers 4 and 5
    logic       delay_dyn;  // Fine delay follows its input
    logic       fb_ext;     // External feedback selected
    logic [1:0] ref_sel;    // 0 pin, 1 low osc, 2 high osc, 3 fabric
  } gcn_ctrl_t;
  // Divider register
  typedef struct packed {
    logic [2:0] out_log2;   // Output divider exponent
    logic [6:0] fb_div;     // Feedback divider, the multiplier
  } gcn_div_t;
  // Logic block routing register
  typedef struct packed {
    logic [2:0] logic3;
    logic [2:0] logic2;
    logic [2:0] logic1;
    logic [2:0] logic0;
    logic [1:0] ce_sel;     // Odd buffer 2*n+1
    logic [1:0] sr_sel;     // Even buffer 2*n
    logic [2:0] clk_sel;    // Any buffer
  } gcn_route_t;
endpackage

// ### tb/gcn_top_props.sv
// Port-level checker for the global clock network
`timescale 1ns/1ps
module gcn_top_props #(
  parameter int N_IO     = 8,
  parameter int LOCK_CYC = 500
) (
  // Clock, reset and bus
  input wire logic            I_SYS_CLK,
  input wire logic            I_RST,
  input wire logic            I_WB_CYC,
  input wire logic            I_WB_STB,
  input wire logic            O_WB_ACK,
  // Configuration and pads
  input wire logic            I_CFG_ACTIVE,
  input wire logic            O_GLOBAL_HIZ_CTL,
  input wire logic            O_GLOBAL_RESET,
  input wire logic            O_LB_SR,
  input wire logic [N_IO-1:0] O_IO_OE_N,
  input wire logic [7:0]      O_GPIO_IN,
  // PLL
  input wire logic            I_PLL_RESET_N,
  input wire logic            I_BYPASS,
  input wire logic            I_LOWPOWER_FREEZE,
  input wire logic            I_GATE_ENABLE_A,
  input wire logic            O_SYNTH_CLOCK_GLOBAL,
  input wire logic            O_SYNTH_CLOCK_FABRIC,
  input wire logic            O_LOCK
);
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);
  // ==========================================================
  // Cycles since the PLL reset or configuration last let go; saturates so it never wraps
  logic [15:0] since_reg;
  logic [15:0] since_next;
  always_comb begin
    since_next = (since_reg == 16'hFFFF) ? since_reg : since_reg + 16'h0001;
    if (!I_PLL_RESET_N || I_CFG_ACTIVE) since_next = 16'h0000;
  end
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) since_reg <= 16'h0000;
    else since_reg <= since_next;
  end
  // ==========================================================
  sequence req_s;
    I_WB_CYC && I_WB_STB && !O_WB_ACK && !I_CFG_ACTIVE;
  endsequence
  sequence frozen_s;
    (I_LOWPOWER_FREEZE && I_GATE_ENABLE_A && !I_BYPASS)[*3];
  endsequence
  a_ack_one_pulse: assert property (req_s |=> O_WB_ACK ##1 !O_WB_ACK) else $error("ack not a single pulse");
  a_hiz_in_cfg: assert property (I_CFG_ACTIVE |=> O_GLOBAL_HIZ_CTL && (&O_IO_OE_N)) else $error("pads live");
  a_hiz_after_cfg: assert property (!I_CFG_ACTIVE |=> !O_GLOBAL_HIZ_CTL && !O_GLOBAL_RESET) else $error("cfg held");
  a_greset_in_cfg: assert property (I_CFG_ACTIVE |=> O_GLOBAL_RESET && O_LB_SR) else $error("reset low");
  a_lock_in_reset: assert property (!I_PLL_RESET_N |=> !O_LOCK) else $error("lock in PLL reset");
  a_lock_too_early: assert property (O_LOCK |-> since_reg >= 16'(LOCK_CYC)) else $error("lock early");
  a_outputs_match: assert property (O_SYNTH_CLOCK_FABRIC == O_SYNTH_CLOCK_GLOBAL) else $error("outputs differ");
  a_osc_not_gpio: assert property (O_GPIO_IN[5:4] == 2'b00) else $error("osc buffers as gpio");
  a_freeze_hold: assert property (frozen_s |=> $stable(O_SYNTH_CLOCK_GLOBAL)) else $error("output moved");
endmodule
bind gcn_top gcn_top_props #(.N_IO(N_IO), .LOCK_CYC(LOCK_CYC)) gcn_top_props_i (.*);

// ### tb/gcn_fabric_model.sv
// Fabric-side model: reference clocks and serial reprogramming master
`timescale 1ns/1ps
module gcn_fabric_model #(
  parameter int REF_HALF = 4,
  parameter int FAB_HALF = 2
) (
  input  wire logic i_clk,
  output logic      o_ref_pin,
  output logic      o_ref_fabric,
  output logic      o_sclk,
  output logic      o_sdin
);
  int ref_cnt = 0; // Half-period counters
  int fab_cnt = 0;
  initial begin
    o_ref_pin    = 1'b0;
    o_ref_fabric = 1'b0;
    o_sclk       = 1'b0;
    o_sdin       = 1'b0;
  end
  // ==========================================================
  // Free-running references, each changed just after every REF_HALF-th or FAB_HALF-th rising edge
  always @(posedge i_clk) begin
    ref_cnt <= (ref_cnt == REF_HALF - 1) ? 0 : ref_cnt + 1;
    fab_cnt <= (fab_cnt == FAB_HALF - 1) ? 0 : fab_cnt + 1;
    if (ref_cnt == REF_HALF - 1) o_ref_pin <= !o_ref_pin;
    if (fab_cnt == FAB_HALF - 1) o_ref_fabric <= !o_ref_fabric;
  end
  // ==========================================================
  // One word, MSB first; data flips off-bit so a stale level never looks valid
  task automatic send_word(input logic [15:0] w);
    for (int b = 15; b >= 0; b--) begin
      @(posedge i_clk);
      o_sdin <= w[b];
      o_sclk <= 1'b1;
      @(posedge i_clk);
      o_sclk <= 1'b0;
      o_sdin <= ~w[b];
    end
  endtask
endmodule

// ### tb/gcn_top_test.sv
// Self-checking bench for the global clock network
`timescale 1ns/1ps
module gcn_top_test;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack, cfg = 0;
  logic [7:0] adr = 0, pins = 0, gpio, global_buffer, io_out = 8'hA5, io_drv = 8'hFF, o_io, oe_n, fdel = 0;
  logic [3:0] sel = 4'hF, lb_logic;
  logic [31:0] wdat = 0, rdat, q;
  logic lb_clk, lb_sr, lb_ce, ref_p, ref_f, extfb = 0, prst_n = 0, byp = 0, frz = 0, gate = 1, sclk, sdin, sg, sf, lock;
  logic [2:0] mon;
  int n_mismatch = 0, n_compared = 0, n;
  assign mon = {global_buffer[5], global_buffer[4], sg};
  // Register rows: sel, address, write data, expected read
  logic [75:0] rows [6] = '{{4'hF, 8'h00, 32'hFFFF_FFFF, 32'h0000_001F}, {4'hF, 8'h04, 32'hFFFF_FFFF, 32'h0000_03FF},
    {4'hF, 8'h08, 32'h0000_0000, 32'h0000_0000}, {4'h1, 8'h08, 32'hFFFF_FFFF, 32'h0000_00FF},
    {4'hF, 8'h0C, 32'hFFFF_FFFF, 32'h0000_00FF}, {4'hF, 8'h18, 32'hFFFF_FFFF, 32'h0000_0000}};
  // PLL rows: control, divider, bypass, toggles in 64 cycles
  logic [31:0] prow [8] = '{{8'h00, 16'h0001, 1'b1, 7'd16}, {8'h03, 16'h0001, 1'b1, 7'd32},
    {8'h01, 16'h0001, 1'b1, 7'd16}, {8'h02, 16'h0001, 1'b1, 7'd64},
    {8'h00, 16'h0001, 1'b0, 7'd16}, {8'h00, 16'h0002, 1'b0, 7'd32}, {8'h00, 16'h0082, 1'b0, 7'd16},
    {8'h00, 16'h0102, 1'b0, 7'd8}};
  initial forever #50 clk = ~clk;
  gcn_fabric_model gcn_fabric_model_i (.i_clk(clk), .o_ref_pin(ref_p), .o_ref_fabric(ref_f), .o_sclk(sclk),
    .o_sdin(sdin));
  gcn_top #(.LF_HALF(4), .HF_HALF(1), .LOCK_CYC(20)) gcn_top_i (.I_SYS_CLK(clk), .I_RST(rst), .I_WB_CYC(cyc),
    .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
    .I_CFG_ACTIVE(cfg), .O_GLOBAL_HIZ_CTL(), .O_GLOBAL_RESET(), .I_GLOBAL_PIN(pins), .O_GPIO_IN(gpio),
    .O_GLOBAL_BUFFER(global_buffer), .I_IO_OUT(io_out), .I_IO_DRIVE(io_drv), .O_IO_OUT(o_io), .O_IO_OE_N(oe_n),
    .O_LB_CLK(lb_clk), .O_LB_LOGIC(lb_logic), .O_LB_SR(lb_sr), .O_LB_CE(lb_ce), .I_REF_CLOCK_IN(ref_p),
    .I_REF_FABRIC(ref_f), .I_EXT_FEEDBACK_IN(extfb), .I_PLL_RESET_N(prst_n), .I_BYPASS(byp),
    .I_FINE_DELAY_CTL(fdel), .I_LOWPOWER_FREEZE(frz), .I_GATE_ENABLE_A(gate), .I_CFG_SERIAL_CLK(sclk),
    .I_CFG_SERIAL_DIN(sdin), .O_SYNTH_CLOCK_GLOBAL(sg), .O_SYNTH_CLOCK_FABRIC(sf), .O_LOCK(lock));
  // ==========================================================
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Classic cycle: hold until ack is sampled high, take data at that edge
  task automatic wb(input logic [7:0] a, input logic w, input logic [3:0] s, input logic [31:0] d);
    int t;
    @(posedge clk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; sel <= s; wdat <= d;
    t = 0;
    do begin @(posedge clk); t++; end while (ack !== 1'b1 && t < 20);
    q = rdat;
    if (t >= 20) cmp("ack", 1, 0);
    cyc <= 0; stb <= 0;
  endtask
  task automatic toggles(input int b, output int c);
    logic p;
    c = 0;
    p = mon[b];
    repeat (64) begin @(posedge clk); if (mon[b] !== p) c++; p = mon[b]; end
  endtask
  task automatic wait_lock(input logic v, input int lim);
    int t;
    t = 0;
    while (lock !== v && t < lim) begin @(posedge clk); t++; end
  endtask
  task automatic close_out();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #3000000;
    n_mismatch++;
    close_out();
  end
  // ==========================================================
  initial begin
    repeat (10) @(posedge clk);
    cmp("reset pads", 32'h0000_01FF, {lb_sr, oe_n});
    rst <= 0;
    foreach (rows[i]) begin
      wb(rows[i][71:64], 1, rows[i][75:72], rows[i][63:32]);
      wb(rows[i][71:64], 0, 4'hF, 0);
      cmp("reg", rows[i][31:0], q);
    end
    // Routing: pin buffers onto clock, set/reset, enable and logic taps
    wb(8'h0C, 1, 4'hF, 32'h0000_00CF);
    for (int k = 0; k < 4; k++) if (k != 2) for (int j = 0; j < 2; j++) begin
      wb(8'h08, 1, 4'hF, (2 * k) * 32'h0001_0401 + (k << 3) + (k << 5) + (2 * k + 1) * 32'h0000_2080);
      pins <= 8'h01 << (2 * k + j);
      repeat (6) @(posedge clk);
      cmp("buffers", 8'h01 << (2 * k + j), global_buffer & 8'hCF);
      cmp("taps", j ? 7'h2C : 7'h53, {lb_logic, lb_ce, lb_sr, lb_clk});
      cmp("gpio used", 0, gpio);
    end
    wb(8'h0C, 1, 4'hF, 0);
    wb(8'h00, 1, 4'hF, 0);
    pins <= 8'hFF;
    repeat (6) @(posedge clk);
    cmp("gpio free", 8'hCF, gpio);
    toggles(1, n);
    cmp("lf osc", 16, n);
    toggles(2, n);
    cmp("hf osc", 64, n);
    // Frequency rows
    prst_n <= 1;
    foreach (prow[i]) begin
      wb(8'h00, 1, 4'hF, prow[i][31:24]);
      wb(8'h04, 1, 4'hF, prow[i][23:8]);
      byp <= prow[i][7];
      repeat (40) @(posedge clk);
      toggles(0, n);
      cmp("synth toggles", prow[i][6:0], n);
    end
    wb(8'h00, 1, 4'hF, 32'h0000_0010);
    repeat (40) @(posedge clk);
    toggles(1, n);
    cmp("synth on buffer", 8, n);
    // Lock, reset, delay, freeze, feedback
    wb(8'h00, 1, 4'hF, 0);
    wb(8'h04, 1, 4'hF, 1);
    prst_n <= 0;
    repeat (3) @(posedge clk);
    toggles(0, n);
    cmp("held", 32'h0000_0000, {n[30:0], lock});
    prst_n <= 1;
    wait_lock(1, 300);
    cmp("lock", 1, lock);
    fdel <= 8'h33;
    repeat (20) @(posedge clk);
    cmp("static delay", 1, lock);
    wb(8'h00, 1, 4'hF, 32'h0000_0008);
    fdel <= 8'h34;
    wait_lock(0, 20);
    cmp("dyn drop", 0, lock);
    wait_lock(1, 300);
    cmp("relock", 1, lock);
    frz <= 1;
    repeat (3) @(posedge clk);
    toggles(0, n);
    cmp("frozen", 0, n);
    frz <= 0;
    wb(8'h00, 1, 4'hF, 32'h0000_0004);
    repeat (100) @(posedge clk);
    cmp("ext feedback", 0, lock);
    gcn_fabric_model_i.send_word(16'h0082);
    wb(8'h04, 0, 4'hF, 0);
    cmp("serial div", 32'h0000_0082, q);
    wb(8'h14, 0, 4'hF, 0);
    cmp("serial word", 32'h0000_0082, q);
    // Configuration forces pads off and clears registers
    wb(8'h0C, 1, 4'hF, 32'h0000_000F);
    cfg <= 1;
    repeat (3) @(posedge clk);
    cmp("cfg", 32'h0000_01FF, {lb_sr, oe_n});
    cfg <= 0;
    repeat (3) @(posedge clk);
    cmp("pads", 32'h0000_A500, {o_io, oe_n});
    wb(8'h0C, 0, 4'hF, 0);
    cmp("cleared", 0, q);
    close_out();
  end
endmodule
